/* dv/analog_trim_register_bank_bench.sv */
// self-checking bench for the trim register bank
// assumes bank and loader share one 100 MHz clock; ce driven here
`timescale 1ns/10ps
module analog_trim_register_bank_bench
    import trim_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] b_addr = '0, l_addr, addr;
    logic [DATA_W-1:0] b_wdata = '0, l_wdata, wr_data, rd_data;
    logic              b_wr = 1'b0, l_wr, rd_stb = 1'b0, wr_stb;
    logic              low_power_mode = 1'b0, ld_start = 1'b0, use_ld = 1'b0, ld_done;
    logic              lin_slope_adjust, bandgap_slope_up, bandgap_slope_down;
    logic              sleep_ref_trim_lock;
    logic              ce = 1'b1;
    logic [CODE_W-1:0] wdog_clk_trim_code, current_ref_trim_code;
    logic [CODE_W-1:0] sleep_ref_trim_code, adc_offset_trim_code;
    logic [15:0]       outs;
    int                miscompares = 0;
    int                comparisons = 0;

    always #5 mclk = ~mclk;
    assign addr    = use_ld ? l_addr : b_addr;
    assign wr_data = use_ld ? l_wdata : b_wdata;
    assign wr_stb  = use_ld ? l_wr : b_wr;
    assign outs = {lin_slope_adjust, wdog_clk_trim_code, bandgap_slope_up, bandgap_slope_down,
                   current_ref_trim_code, sleep_ref_trim_code, sleep_ref_trim_lock,
                   adc_offset_trim_code};

    analog_trim_register_bank u_analog_trim_register_bank (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .low_power_mode(low_power_mode), .lin_slope_adjust(lin_slope_adjust),
        .wdog_clk_trim_code(wdog_clk_trim_code), .bandgap_slope_up(bandgap_slope_up),
        .bandgap_slope_down(bandgap_slope_down),
        .current_ref_trim_code(current_ref_trim_code),
        .sleep_ref_trim_code(sleep_ref_trim_code),
        .sleep_ref_trim_lock(sleep_ref_trim_lock),
        .adc_offset_trim_code(adc_offset_trim_code));

    trim_loader #(.FLASH_WORDS(32'hd515_b8e3)) u_trim_loader (
        .mclk(mclk), .rst_n(rst_n), .start(ld_start), .addr(l_addr),
        .wr_data(l_wdata), .wr_stb(l_wr), .done(ld_done));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        b_addr  <= a;
        b_wdata <= d;
        b_wr    <= 1'b1;
        @(posedge mclk);
        b_wr    <= 1'b0;
    endtask : wr

    // with ce high, read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge mclk);
        b_addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        check({8'h00, rd_data}, {8'h00, exp});
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic reset_defaults();
        for (int i = 0; i < 4; i++) begin
            rd(10'h2f0 + 10'(i), 8'h00);
        end
        check(outs, 16'h0000);
    endtask : reset_defaults

    task automatic startup_copy();
        int n;
        n = 0;
        @(posedge mclk);
        use_ld   <= 1'b1;
        ld_start <= 1'b1;
        @(posedge mclk);
        ld_start <= 1'b0;
        while (!ld_done && n < 50) begin
            @(posedge mclk);
            n++;
        end
        use_ld <= 1'b0;
        if (n >= 50) begin
            check(16'h0000, 16'h0001);
        end else begin
            rd(10'h2f0, 8'he3);
            rd(10'h3f1, 8'hb8);
            rd(10'h2f2, 8'h15);
            rd(10'h3f3, 8'hd5);
            // up and down both set cancel to the default slope
            check(outs, {1'b1, 3'h3, 1'b0, 1'b0, 3'h0, 3'h5, 1'b0, 3'h5});
        end
    endtask : startup_copy

    task automatic enables_off();
        wr(10'h2f0, 8'h5b);
        wr(10'h2f1, 8'h77);
        wr(10'h2f3, 8'h55);
        settle();
        check(outs, {1'b0, 3'h0, 1'b0, 1'b0, 3'h0, 3'h5, 1'b0, 3'h0});
        rd(10'h2f0, 8'h5b);
        wr(10'h3f1, 8'h95);
        wr(10'h3f0, 8'ha4);
        settle();
        check(outs, {1'b0, 3'h4, 1'b0, 1'b1, 3'h0, 3'h5, 1'b0, 3'h0});
        rd(10'h2f1, 8'h95);
        wr(10'h2f1, 8'ha0);
        settle();
        check(outs, {1'b0, 3'h4, 1'b1, 1'b0, 3'h0, 3'h5, 1'b0, 3'h0});
        wr(10'h3f1, 8'h2e);
        settle();
        check(outs, {1'b0, 3'h4, 1'b0, 1'b0, 3'h6, 3'h5, 1'b0, 3'h0});
    endtask : enables_off

    task automatic unmapped_and_low_power();
        wr(10'h2f4, 8'hff);
        rd(10'h2f4, 8'h00);
        rd(10'h1f0, 8'h00);
        @(posedge mclk);
        low_power_mode <= 1'b1;
        wr(10'h2f0, 8'h00);
        rd(10'h2f0, 8'ha4);
        @(posedge mclk);
        low_power_mode <= 1'b0;
        ce             <= 1'b0;
        wr(10'h2f0, 8'h00);
        @(posedge mclk);
        ce <= 1'b1;
        rd(10'h2f0, 8'ha4);
    endtask : unmapped_and_low_power

    task automatic sleep_lock();
        wr(10'h2f2, 8'hf1);
        rd(10'h2f2, 8'h11);
        wr(10'h2f2, 8'h12);
        rd(10'h3f2, 8'h12);
        wr(10'h2f2, 8'h1e);
        settle();
        check(outs[6:3], {3'h6, 1'b1});
        wr(10'h3f2, 8'h11);
        wr(10'h2f2, 8'h00);
        rd(10'h2f2, 8'h1e);
        check(outs[6:3], {3'h6, 1'b1});
        wr(10'h2f0, 8'h81);
        rd(10'h2f0, 8'h81);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        rst_n <= 1'b1;
        reset_defaults();
        wr(10'h2f2, 8'h13);
        rd(10'h2f2, 8'h13);
    endtask : sleep_lock

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        reset_defaults();
        startup_copy();
        enables_off();
        unmapped_and_low_power();
        sleep_lock();
        summarize();
    end
endmodule : analog_trim_register_bank_bench

/* dv/trim_loader.sv */
// partner model: controller software doing the startup trim copy
// assumes the byte port of the trim bank, same clock, no wait states
`timescale 1ns/10ps
module trim_loader
    import trim_pkg::*;
#(
    parameter logic [31:0] FLASH_WORDS = 32'h0000_0000
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              start,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wr_data,
    output logic                   wr_stb,
    output logic                   done
);
    logic [2:0] step_r;
    logic       busy_r;
    logic [1:0] idx;

    assign idx = (step_r < 3'h2) ? step_r[1:0] : 2'(step_r - 3'h1);

    // no channel 14 conversions started here
    // four bytes in order, as two pairs of byte writes
    always_ff @(posedge mclk) begin
        wr_stb <= 1'b0;
        done   <= 1'b0;
        if (!rst_n) begin
            step_r  <= 3'h0;
            busy_r  <= 1'b0;
            addr    <= 10'h000;
            wr_data <= 8'h00;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
            step_r <= 3'h0;
        end else if (busy_r) begin
            step_r <= step_r + 3'h1;
            if (step_r == 3'h5) begin
                busy_r <= 1'b0;
                done   <= 1'b1;
            end else if (step_r != 3'h2) begin
                wr_stb  <= 1'b1;
                addr    <= BLOCK_BASE + {2'h0, OFS_TRIM0} + {8'h00, idx};
                wr_data <= FLASH_WORDS[8*idx +: 8];
            end else begin
                // released lines do not keep their last value
                addr    <= ~addr;
                wr_data <= ~wr_data;
            end
        end
    end
endmodule : trim_loader

/* rtl/analog_trim_register_bank.sv */
// analog die trim register bank: four byte registers and gated trim codes
// assumes a same-clock master on a plain strobe port, no wait states
`timescale 1ns/10ps

// Functional notes
// - contents held in low power; reset restores defaults
// - registers at 0xf0-0xf3 in both windows
// - code, enable, lock in one write; then frozen
// - trim0 bit7 enables lin slope bit6
// - trim0 bit5 enables watchdog code bits 2-0
// - trim1 bit7 enables bandgap up/down slope
// - trim1 bit3 enables current reference code
// - trim0 and trim1 full read/write, reset zero
// - trim2 bit4 enable, bit3 lock, code 2-0
// - trim3 bit7 enables adc offset code 6-4
module analog_trim_register_bank
    import trim_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              low_power_mode,
    output logic                   lin_slope_adjust,
    output logic      [CODE_W-1:0] wdog_clk_trim_code,
    output logic                   bandgap_slope_up,
    output logic                   bandgap_slope_down,
    output logic      [CODE_W-1:0] current_ref_trim_code,
    output logic      [CODE_W-1:0] sleep_ref_trim_code,
    output logic                   sleep_ref_trim_lock,
    output logic      [CODE_W-1:0] adc_offset_trim_code
);
    logic [2:0]        dec;
    logic              hit;
    logic [1:0]        idx;
    logic [7:0]        regs [NUM_REGS];
    logic [NUM_REGS-1:0] wr_en;
    logic [7:0]        rd_data_r;
    logic [7:0]        trim0_q;
    logic [7:0]        trim1_q;
    logic [7:0]        trim2_q;
    logic [7:0]        trim3_q;
    logic              lock;
    logic [1:0]        bg_code;
    logic [1:0]        bg_out;

    assign dec = trim_decode(addr);
    assign hit = dec[2];
    assign idx = dec[1:0];

    assign trim0_q = regs[0];
    assign trim1_q = regs[1];
    assign trim2_q = regs[2];
    assign trim3_q = regs[3];
    assign lock    = trim2_q[SLP_LOCK_BIT];

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            wr_en[i] = wr_stb && hit && (idx == 2'(i)) && !low_power_mode;
        end
        if (lock) begin
            wr_en[2] = 1'b0;
        end
    end

    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
        localparam logic [7:0] MASK = (g == 2) ? MASK_TRIM2 : MASK_FULL;
        trim_byte_reg #(
            .WRITE_MASK (MASK),
            .RESET_VAL  (RST_TRIM)
        ) u_reg (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .ce      (ce),
            .wr_en   (wr_en[g]),
            .wr_data (wr_data),
            .q       (regs[g])
        );
    end

    // read data one cycle after the strobe, zero on other cycles with ce high; held while ce is low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_data_r <= RD_IDLE;
        end else if (ce) begin
            if (rd_stb && hit) begin
                rd_data_r <= regs[idx];
            end else begin
                rd_data_r <= RD_IDLE;
            end
        end
    end

    assign rd_data = rd_data_r;

    trim_code_gate #(
        .W        (1),
        .IDLE_VAL (1'b0)
    ) u_lin (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim0_q[LIN_EN_BIT]),
        .code     (trim0_q[LIN_ADJ_BIT]),
        .trim_out (lin_slope_adjust)
    );

    trim_code_gate #(
        .W        (CODE_W),
        .IDLE_VAL (3'h0)
    ) u_wdog (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim0_q[WD_EN_BIT]),
        .code     (trim0_q[WD_LSB +: CODE_W]),
        .trim_out (wdog_clk_trim_code)
    );

    // up and down together cancel, so the slope stays default
    assign bg_code = (trim1_q[BG_UP_BIT] && trim1_q[BG_DN_BIT]) ? 2'b00
                   : {trim1_q[BG_UP_BIT], trim1_q[BG_DN_BIT]};

    trim_code_gate #(
        .W        (2),
        .IDLE_VAL (2'b00)
    ) u_bg (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim1_q[BG_EN_BIT]),
        .code     (bg_code),
        .trim_out (bg_out)
    );

    assign bandgap_slope_up   = bg_out[1];
    assign bandgap_slope_down = bg_out[0];

    trim_code_gate #(
        .W        (CODE_W),
        .IDLE_VAL (3'h0)
    ) u_iref (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim1_q[IREF_EN_BIT]),
        .code     (trim1_q[IREF_LSB +: CODE_W]),
        .trim_out (current_ref_trim_code)
    );

    // sleep reference; idle code is the default step
    // disabled trim falls back to default
    trim_code_gate #(
        .W        (CODE_W),
        .IDLE_VAL (SLEEP_DEFAULT)
    ) u_sleep (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim2_q[SLP_EN_BIT]),
        .code     (trim2_q[SLP_LSB +: CODE_W]),
        .trim_out (sleep_ref_trim_code)
    );

    trim_code_gate #(
        .W        (CODE_W),
        .IDLE_VAL (3'h0)
    ) u_adc (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .en       (trim3_q[ADC_EN_BIT]),
        .code     (trim3_q[ADC_LSB +: CODE_W]),
        .trim_out (adc_offset_trim_code)
    );

    // lock straight from storage so software sees it at once
    assign sleep_ref_trim_lock = lock;

    // checks, all on mclk; all but p_lock_reset with reset as the disable
    property p_rst_defaults;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> (trim0_q == RST_TRIM) && (trim1_q == RST_TRIM)
                      && (trim2_q == RST_TRIM) && (trim3_q == RST_TRIM);
    endproperty
    a_rst_defaults: assert property (p_rst_defaults)
        else $error("trim registers not at default after reset");

    property p_lp_hold;
        @(posedge mclk) disable iff (!rst_n)
        rst_n && low_power_mode |=> $stable({trim0_q, trim1_q, trim2_q, trim3_q});
    endproperty
    a_lp_hold: assert property (p_lp_hold)
        else $error("trim register changed in low power");

    property p_win_read;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && rd_stb && (addr == (NONBLOCK_BASE | 10'(OFS_TRIM1)))
        |=> rd_data == $past(trim1_q)
            ##1 (rd_data == RD_IDLE || $past(rd_stb) || !$past(ce));
    endproperty
    a_win_read: assert property (p_win_read)
        else $error("non-blocking window read wrong");

    property p_unmapped_read;
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_stb && !hit |=> rd_data == RD_IDLE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_lock_apply;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && wr_stb && !lock && !low_power_mode
        && (addr == (BLOCK_BASE | 10'(OFS_TRIM2)))
        && wr_data[SLP_EN_BIT] && wr_data[SLP_LOCK_BIT]
        |=> lock && trim2_q[SLP_LSB +: CODE_W] == $past(wr_data[2:0])
            ##1 (!ce || sleep_ref_trim_code == $past(trim2_q[2:0]));
    endproperty
    a_lock_apply: assert property (p_lock_apply)
        else $error("sleep trim not applied and locked");

    property p_lock_freeze;
        @(posedge mclk) disable iff (!rst_n)
        lock && rst_n |=> lock && $stable(trim2_q);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze)
        else $error("locked sleep trim changed");

    property p_lin_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n |=> lin_slope_adjust
               == ($past(trim0_q[LIN_EN_BIT]) && $past(trim0_q[LIN_ADJ_BIT]));
    endproperty
    a_lin_gate: assert property (p_lin_gate)
        else $error("lin slope output wrong");

    property p_wdog_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n |=> wdog_clk_trim_code
               == ($past(trim0_q[WD_EN_BIT]) ? $past(trim0_q[2:0]) : 3'h0);
    endproperty
    a_wdog_gate: assert property (p_wdog_gate)
        else $error("watchdog trim output wrong");

    property p_bg_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && !trim1_q[BG_EN_BIT] |=> !bandgap_slope_up && !bandgap_slope_down;
    endproperty
    a_bg_gate: assert property (p_bg_gate)
        else $error("bandgap slope active while disabled");

    property p_bg_up;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && trim1_q[BG_EN_BIT] && trim1_q[BG_UP_BIT] && !trim1_q[BG_DN_BIT]
        |=> bandgap_slope_up && !bandgap_slope_down;
    endproperty
    a_bg_up: assert property (p_bg_up)
        else $error("bandgap slope up not passed");

    property p_iref_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n |=> current_ref_trim_code
               == ($past(trim1_q[IREF_EN_BIT]) ? $past(trim1_q[2:0]) : 3'h0);
    endproperty
    a_iref_gate: assert property (p_iref_gate)
        else $error("current reference trim output wrong");

    property p_full_write;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && wr_stb && !low_power_mode
        && (addr == (BLOCK_BASE | 10'(OFS_TRIM1)))
        |=> trim1_q == $past(wr_data);
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("trim1 write not stored in full");

    property p_trim2_upper;
        @(posedge mclk) disable iff (!rst_n)
        trim2_q[7:5] == 3'h0;
    endproperty
    a_trim2_upper: assert property (p_trim2_upper)
        else $error("trim2 upper bits not zero");

    property p_sleep_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && !trim2_q[SLP_EN_BIT] |=> sleep_ref_trim_code == SLEEP_DEFAULT;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("sleep trim passed while disabled");

    property p_adc_gate;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n |=> adc_offset_trim_code
               == ($past(trim3_q[ADC_EN_BIT]) ? $past(trim3_q[6:4]) : 3'h0);
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("adc offset trim output wrong");

    property p_ce_freeze;
        @(posedge mclk) disable iff (!rst_n)
        !ce && rst_n |=> $stable({trim0_q, trim1_q, trim2_q, trim3_q, rd_data});
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state changed with clock enable low");

    // reset edge must clear the lock even with ce low
    property p_lock_reset;
        @(posedge mclk)
        !rst_n |=> !lock && (trim2_q == RST_TRIM);
    endproperty
    a_lock_reset: assert property (p_lock_reset)
        else $error("sleep trim lock not cleared by reset");

    property p_full_write0;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && wr_stb && !low_power_mode
        && (addr == (BLOCK_BASE | 10'(OFS_TRIM0)))
        |=> trim0_q == $past(wr_data);
    endproperty
    a_full_write0: assert property (p_full_write0)
        else $error("trim0 write not stored in full");

    property p_rd_idle;
        @(posedge mclk) disable iff (!rst_n)
        ce && rst_n && !rd_stb |=> rd_data == RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle outside a read");
endmodule : analog_trim_register_bank

/* rtl/trim_byte_reg.sv */
// one byte of trim storage with a per-bit write mask
// assumes write enable already qualified by address and lock
`timescale 1ns/10ps
module trim_byte_reg
    import trim_pkg::*;
#(
    parameter logic [7:0] WRITE_MASK = MASK_FULL,
    parameter logic [7:0] RESET_VAL  = RST_TRIM
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] q
);
    logic [7:0] q_r;

    // masked bits stay at their reset value, read back as zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_r <= RESET_VAL;
        end else if (ce && wr_en) begin
            q_r <= (q_r & ~WRITE_MASK) | (wr_data & WRITE_MASK);
        end
    end

    assign q = q_r;
endmodule : trim_byte_reg

/* rtl/trim_code_gate.sv */
// registered trim code, forced to the untrimmed value while disabled
// assumes enable and code come from the same clock domain
`timescale 1ns/10ps
module trim_code_gate
    import trim_pkg::*;
#(
    parameter int           W        = CODE_W,
    parameter logic [W-1:0] IDLE_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         en,
    input  wire logic [W-1:0] code,
    output logic      [W-1:0] trim_out
);
    logic [W-1:0] out_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_r <= IDLE_VAL;
        end else if (ce) begin
            out_r <= en ? code : IDLE_VAL;
        end
    end

    assign trim_out = out_r;
endmodule : trim_code_gate

/* rtl/trim_pkg.sv */
// trim register bank constants: addresses, field layout, reset values
// assumes a byte-wide register port on the die-to-die bus clock
package trim_pkg;
    localparam int          ADDR_W         = 10;
    localparam int          DATA_W         = 8;
    localparam int          CODE_W         = 3;
    localparam int          NUM_REGS       = 4;
    localparam logic [9:0]  BLOCK_BASE     = 10'h200;
    localparam logic [9:0]  NONBLOCK_BASE  = 10'h300;
    localparam logic [7:0]  OFS_TRIM0      = 8'hf0;
    localparam logic [7:0]  OFS_TRIM1      = 8'hf1;
    localparam logic [7:0]  OFS_TRIM2      = 8'hf2;
    localparam logic [7:0]  OFS_TRIM3      = 8'hf3;
    localparam logic [7:0]  RST_TRIM       = 8'h00;
    localparam logic [7:0]  MASK_FULL      = 8'hff;
    localparam logic [7:0]  MASK_TRIM2     = 8'h1f;
    localparam logic [7:0]  RD_IDLE        = 8'h00;
    localparam logic [2:0]  SLEEP_DEFAULT  = 3'h0;
    // trim0 fields
    localparam int          LIN_EN_BIT     = 7;
    localparam int          LIN_ADJ_BIT    = 6;
    localparam int          WD_EN_BIT      = 5;
    localparam int          WD_LSB         = 0;
    // trim1 fields
    localparam int          BG_EN_BIT      = 7;
    localparam int          BG_UP_BIT      = 5;
    localparam int          BG_DN_BIT      = 4;
    localparam int          IREF_EN_BIT    = 3;
    localparam int          IREF_LSB       = 0;
    // trim2 fields
    localparam int          SLP_EN_BIT     = 4;
    localparam int          SLP_LOCK_BIT   = 3;
    localparam int          SLP_LSB        = 0;
    // trim3 fields
    localparam int          ADC_EN_BIT     = 7;
    localparam int          ADC_LSB        = 4;

    // {hit, index}; both bus windows land on the same four registers
    function automatic logic [2:0] trim_decode(input logic [9:0] addr);
        logic [9:0] base;
        logic [7:0] ofs;
        base = {addr[9:8], 8'h00};
        ofs  = addr[7:0];
        trim_decode = 3'h0;
        if ((base == BLOCK_BASE || base == NONBLOCK_BASE) &&
            ofs >= OFS_TRIM0 && ofs <= OFS_TRIM3) begin
            trim_decode = {1'b1, ofs[1:0]};
        end
    endfunction : trim_decode
endpackage : trim_pkg
